/* File: core/btc_core.sv */
// Purpose: execution of bit-test branches, loop branches and interrupt enable control
// Assumes: operand byte already fetched and presented with the start pulse
// Notes: busy for all but the last of the documented cycle count in cpu clocks, results post in the last
//
// Contract
// - branch-if-bit-set jumps by displacement only when bit is one; 3 bytes, 8 cycles; code takes 8 only for acc and hsram saddr, sfr is 4 bytes, 11.
// - register loop decrements register, branches when nonzero; 2 bytes, 6 cycles.
// - memory loop decrements and writes back byte, branches when nonzero; 8/10 cycles.
// - interrupt enable instruction sets master enable; 2 bytes, 6 cycles.
// - mask instruction clears master enable; 2 bytes, 6 cycles.
// - all timing counted in cpu clock periods.
// - short count for high-speed ram or no data access, long otherwise.
// - pointer forms add read waits, plus write waits when written back.
// - word move into accumulator pair only from the three other pairs.
`timescale 1ns/1ps
module btc_core (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // instruction request
    input wire logic i_start,
    input wire btc_pkg::btc_op_t i_op,
    input wire btc_pkg::btc_space_t i_space,
    input wire logic [2:0] i_bit_sel,
    input wire logic [7:0] i_operand,
    input wire logic [7:0] i_psw,
    input wire logic [7:0] i_jump_displacement,
    input wire logic [15:0] i_pc,
    input wire logic i_hsram,
    input wire logic [3:0] i_wait_rd,
    input wire logic [3:0] i_wait_wr,
    // word move legality check
    input wire logic [1:0] i_register_pair,
    // results
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_next_pc,
    output logic o_branch_taken,
    output logic o_wr_en,
    output logic [7:0] o_wr_data,
    output logic o_psw_wr,
    output logic [7:0] o_psw,
    output logic o_interrupt_master_enable,
    output logic o_word_move_ok
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        BTC_ST_IDLE = 2'h0,
        BTC_ST_RUN = 2'h1,
        BTC_ST_POST = 2'h3
    } btc_state_t;

    btc_state_t state, next_state;
    logic [7:0] count, next_count;
    logic [15:0] next_pc_r, next_next_pc;
    logic taken, next_taken;
    logic wr_en, next_wr_en;
    logic [7:0] wr_data, next_wr_data;
    logic psw_wr, next_psw_wr;
    logic [7:0] psw_out, next_psw_out;
    logic ime, next_ime;
    logic done, next_done;
    logic rp_ok, next_rp_ok;
    // registered copies so every port comes straight from a flop
    logic busy, next_busy;
    logic wr_pulse, next_wr_pulse;
    logic psw_pulse, next_psw_pulse;
    logic [2:0] len;
    logic [7:0] cycles;

    // length and cycle lookup
    btc_timing u_timing (
        .i_op(i_op),
        .i_space(i_space),
        .i_hsram(i_hsram),
        .i_wait_rd(i_wait_rd),
        .i_wait_wr(i_wait_wr),
        .o_len(len),
        .o_cycles(cycles)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode and evaluate at start, then count down the cycle budget
    always_comb begin
        logic bitv;
        logic [7:0] dec;
        logic [15:0] fall;
        logic [15:0] disp16;
        logic [7:0] cleared;
        bitv = i_operand[i_bit_sel];
        dec = i_operand - btc_pkg::BTC_BYTE_ONE;
        fall = i_pc + 16'(len);
        disp16 = {{8{i_jump_displacement[7]}}, i_jump_displacement};
        cleared = i_operand & ~(btc_pkg::BTC_BYTE_ONE << i_bit_sel);
        next_state = state;
        next_count = count;
        next_next_pc = next_pc_r;
        next_taken = taken;
        next_wr_en = wr_en;
        next_wr_data = wr_data;
        next_psw_wr = psw_wr;
        next_psw_out = psw_out;
        next_ime = ime;
        next_done = 1'b0;
        next_rp_ok = (i_register_pair != btc_pkg::BTC_RP_AX);
        unique case (state)
            BTC_ST_IDLE: begin
                if (i_start) begin
                    next_state = BTC_ST_RUN;
                    next_count = cycles - btc_pkg::BTC_CNT_ONE;
                    next_taken = 1'b0;
                    next_wr_en = 1'b0;
                    next_psw_wr = 1'b0;
                    next_wr_data = i_operand;
                    next_psw_out = i_psw;
                    unique case (i_op)
                        btc_pkg::BTC_OP_BSET: next_taken = bitv;
                        btc_pkg::BTC_OP_BCLR: next_taken = !bitv;
                        btc_pkg::BTC_OP_BTCL: begin
                            next_taken = bitv;
                            if (bitv) begin
                                next_wr_data = cleared;
                                next_wr_en = (i_space != btc_pkg::BTC_SP_PSW);
                                next_psw_wr = (i_space == btc_pkg::BTC_SP_PSW);
                                next_psw_out = cleared;
                            end
                        end
                        btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M: begin
                            next_wr_en = 1'b1;
                            next_wr_data = dec;
                            next_taken = (dec != btc_pkg::BTC_BYTE_ZERO);
                        end
                        btc_pkg::BTC_OP_IEN: next_ime = 1'b1;
                        btc_pkg::BTC_OP_IDIS: next_ime = 1'b0;
                        default: next_taken = 1'b0;
                    endcase
                    // untaken falls through to the following instruction
                    next_next_pc = fall;
                    if (next_taken) begin
                        next_next_pc = fall + disp16;
                    end
                end
            end
            BTC_ST_RUN: begin
                // one count per cpu clock; post in the final cycle
                if (count == btc_pkg::BTC_CNT_ONE) begin
                    next_state = BTC_ST_POST;
                    next_done = 1'b1;
                end else begin
                    next_count = count - btc_pkg::BTC_CNT_ONE;
                end
            end
            BTC_ST_POST: begin
                next_state = BTC_ST_IDLE;
                next_wr_en = 1'b0;
                next_psw_wr = 1'b0;
            end
            default: next_state = BTC_ST_IDLE;
        endcase
        // strobes pulse with done; an untaken test-and-clear never writes
        next_busy = (next_state == BTC_ST_RUN);
        next_wr_pulse = next_done && wr_en;
        next_psw_pulse = next_done && psw_wr;
    end

    // register all state
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= BTC_ST_IDLE;
            count <= btc_pkg::BTC_BYTE_ZERO;
            next_pc_r <= 16'h0000;
            taken <= 1'b0;
            wr_en <= 1'b0;
            wr_data <= btc_pkg::BTC_BYTE_ZERO;
            psw_wr <= 1'b0;
            psw_out <= btc_pkg::BTC_BYTE_ZERO;
            ime <= 1'b0;
            done <= 1'b0;
            rp_ok <= 1'b0;
            busy <= 1'b0;
            wr_pulse <= 1'b0;
            psw_pulse <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            next_pc_r <= next_next_pc;
            taken <= next_taken;
            wr_en <= next_wr_en;
            wr_data <= next_wr_data;
            psw_wr <= next_psw_wr;
            psw_out <= next_psw_out;
            ime <= next_ime;
            done <= next_done;
            rp_ok <= next_rp_ok;
            busy <= next_busy;
            wr_pulse <= next_wr_pulse;
            psw_pulse <= next_psw_pulse;
        end
    end

    // outputs straight from flops; write strobes qualified by done
    assign o_busy = busy;
    assign o_done = done;
    assign o_next_pc = next_pc_r;
    assign o_branch_taken = taken;
    assign o_wr_en = wr_pulse;
    assign o_wr_data = wr_data;
    assign o_psw_wr = psw_pulse;
    assign o_psw = psw_out;
    assign o_interrupt_master_enable = ime;
    assign o_word_move_ok = rp_ok;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_start_loop;
        i_start && state == BTC_ST_IDLE && i_op == btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R;
    endsequence

    a_loop_six_cycles: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_start_loop |-> ##6 done) else $error("register loop not done in 6 cycles");
    a_loop_not_early: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_start_loop |-> ##1 !done [*5]) else $error("register loop done early");
    a_ie_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_start && state == BTC_ST_IDLE && i_op == btc_pkg::BTC_OP_IEN) |=> ime)
        else $error("master enable not set");
    a_ie_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_start && state == BTC_ST_IDLE && i_op == btc_pkg::BTC_OP_IDIS) |=> !ime)
        else $error("master enable not cleared");
    a_bset_take: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_start && state == BTC_ST_IDLE && i_op == btc_pkg::BTC_OP_BSET)
        |=> taken == $past(i_operand[i_bit_sel])) else $error("bit set branch wrong");
    a_bclr_take: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_start && state == BTC_ST_IDLE && i_op == btc_pkg::BTC_OP_BCLR)
        |=> taken != $past(i_operand[i_bit_sel])) else $error("bit clear branch wrong");
    a_fall_through: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (done && !taken) |-> !o_psw_wr) else $error("flags written on fall through");
    a_rp_check: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_register_pair == btc_pkg::BTC_RP_AX) |=> !o_word_move_ok)
        else $error("accumulator pair accepted");
    a_loop_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_start && state == BTC_ST_IDLE && i_operand == btc_pkg::BTC_BYTE_ONE
        && i_op inside {btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M}) |=> !taken)
        else $error("loop branched on zero");
endmodule

/* File: core/btc_pkg.sv */
// Purpose: shared constants for the bit-test branch and cpu control unit
// Assumes: 8-bit data, 16-bit program counter, cycle counts in cpu clocks
// Notes: operation and operand codes are local encodings of this unit
package btc_pkg;
    // operation select
    typedef enum logic [2:0] {
        BTC_OP_NONE = 3'h0,
        BTC_OP_BSET = 3'h1,
        BTC_OP_BCLR = 3'h2,
        BTC_OP_BTCL = 3'h3,
        BTC_OP_DECREMENT_BRANCH_NONZERO_R = 3'h4,
        BTC_OP_DECREMENT_BRANCH_NONZERO_M = 3'h5,
        BTC_OP_IEN = 3'h6,
        BTC_OP_IDIS = 3'h7
    } btc_op_t;
    // bit operand space
    typedef enum logic [2:0] {
        BTC_SP_SADDR = 3'h0,
        BTC_SP_SFR = 3'h1,
        BTC_SP_ACC = 3'h2,
        BTC_SP_PSW = 3'h3,
        BTC_SP_HL = 3'h4
    } btc_space_t;
    // register pair codes for the word move check
    localparam logic [1:0] BTC_RP_AX = 2'h0;
    // byte lengths
    localparam logic [2:0] BTC_LEN2 = 3'h2;
    localparam logic [2:0] BTC_LEN3 = 3'h3;
    localparam logic [2:0] BTC_LEN4 = 3'h4;
    // cycle counts
    localparam logic [7:0] BTC_CYC6 = 8'h06;
    localparam logic [7:0] BTC_CYC8 = 8'h08;
    localparam logic [7:0] BTC_CYC9 = 8'h09;
    localparam logic [7:0] BTC_CYC10 = 8'h0A;
    localparam logic [7:0] BTC_CYC11 = 8'h0B;
    localparam logic [7:0] BTC_CYC12 = 8'h0C;
    // psw flag positions
    localparam int BTC_PSW_CY = 0;
    localparam int BTC_PSW_AC = 4;
    localparam int BTC_PSW_Z = 6;
    localparam logic [7:0] BTC_BYTE_ZERO = 8'h00;
    localparam logic [7:0] BTC_BYTE_ONE = 8'h01;
    localparam logic [7:0] BTC_CNT_ONE = 8'h01;
endpackage

/* File: core/btc_timing.sv */
// Purpose: byte length and cycle count lookup for one operation
// Assumes: wait counts are given per access in cpu clocks
// Notes: pure combinational table
`timescale 1ns/1ps
module btc_timing (
    // operation
    input wire btc_pkg::btc_op_t i_op,
    input wire btc_pkg::btc_space_t i_space,
    input wire logic i_hsram,
    input wire logic [3:0] i_wait_rd,
    input wire logic [3:0] i_wait_wr,
    // results
    output logic [2:0] o_len,
    output logic [7:0] o_cycles
);
    // table of lengths and cycles; hsram picks the short column
    always_comb begin
        o_len = btc_pkg::BTC_LEN2;
        o_cycles = btc_pkg::BTC_CYC6;
        unique case (i_op)
            btc_pkg::BTC_OP_BSET, btc_pkg::BTC_OP_BCLR, btc_pkg::BTC_OP_BTCL: begin
                unique case (i_space)
                    btc_pkg::BTC_SP_ACC: begin
                        o_len = btc_pkg::BTC_LEN3;
                        o_cycles = btc_pkg::BTC_CYC8;
                    end
                    btc_pkg::BTC_SP_HL: begin
                        o_len = btc_pkg::BTC_LEN3;
                        // wait states lengthen the pointer form
                        if (i_hsram) begin
                            o_cycles = btc_pkg::BTC_CYC10;
                        end else if (i_op == btc_pkg::BTC_OP_BTCL) begin
                            o_cycles = btc_pkg::BTC_CYC12 + 8'(i_wait_rd) + 8'(i_wait_wr);
                        end else begin
                            o_cycles = btc_pkg::BTC_CYC11 + 8'(i_wait_rd);
                        end
                    end
                    btc_pkg::BTC_SP_SADDR: begin
                        if (i_op == btc_pkg::BTC_OP_BSET) begin
                            o_len = btc_pkg::BTC_LEN3;
                            o_cycles = i_hsram ? btc_pkg::BTC_CYC8 : btc_pkg::BTC_CYC9;
                        end else begin
                            o_len = btc_pkg::BTC_LEN4;
                            o_cycles = i_hsram ? btc_pkg::BTC_CYC10 :
                                ((i_op == btc_pkg::BTC_OP_BTCL) ? btc_pkg::BTC_CYC12
                                                                : btc_pkg::BTC_CYC11);
                        end
                    end
                    default: begin
                        // sfr and psw forms use the long column only
                        o_len = (i_op == btc_pkg::BTC_OP_BSET && i_space == btc_pkg::BTC_SP_PSW)
                            ? btc_pkg::BTC_LEN3 : btc_pkg::BTC_LEN4;
                        if (i_op == btc_pkg::BTC_OP_BTCL) begin
                            o_cycles = btc_pkg::BTC_CYC12;
                        end else if (o_len == btc_pkg::BTC_LEN3) begin
                            o_cycles = btc_pkg::BTC_CYC9;
                        end else begin
                            o_cycles = btc_pkg::BTC_CYC11;
                        end
                    end
                endcase
            end
            btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M: begin
                o_len = btc_pkg::BTC_LEN3;
                o_cycles = i_hsram ? btc_pkg::BTC_CYC8 : btc_pkg::BTC_CYC10;
            end
            default: begin
                // register loop and interrupt control: 2 bytes, 6 cycles
                o_len = btc_pkg::BTC_LEN2;
                o_cycles = btc_pkg::BTC_CYC6;
            end
        endcase
    end
endmodule

/* File: sim/btc_mem_model.sv */
// Purpose: data space model beside the bit-test branch unit
// Assumes: one 256-byte short direct area and one status word
// Notes: write-back lands at the edge that closes the done pulse
`timescale 1ns/1ps
module btc_mem_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // access from the unit
    input wire logic [7:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic i_psw_wr,
    input wire logic [7:0] i_psw,
    // read side
    output logic [7:0] o_byte,
    output logic [7:0] o_psw
);
    logic [7:0] mem [256];
    // fixed fill so the bench can predict loop counts; status word value is arbitrary
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 256; k++) begin
                mem[k] <= 8'(k * 29 + 7);
            end
            o_psw <= 8'h51;
        end else begin
            if (i_wr_en) begin
                mem[i_addr] <= i_wr_data;
            end
            if (i_psw_wr) begin
                o_psw <= i_psw;
            end
        end
    end
    // read is combinational, the unit samples it with its start pulse
    assign o_byte = mem[i_addr];
endmodule

/* File: sim/bit_test_branch_and_cpu_control_bench.sv */
// Purpose: self-checking bench for the bit-test branch and cpu control unit
// Assumes: next start issued two edges after done, clear of the post cycle
// Notes: random operations with a fixed seed plus loop, refusal and status corners
`timescale 1ns/1ps
module bit_test_branch_and_cpu_control_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    btc_pkg::btc_op_t i_op = btc_pkg::BTC_OP_NONE;
    btc_pkg::btc_space_t i_space = btc_pkg::BTC_SP_SADDR;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] reg_val = 8'h00, disp = 8'h00, addr = 8'h00, operand, mem_byte, psw_cur;
    logic [15:0] pc = 16'h0000;
    logic hsram = 1'b1, mem_we, o_busy, o_done, o_branch_taken, o_wr_en, o_psw_wr, o_ime, o_wm_ok;
    logic [3:0] wrd = 4'h0, wwr = 4'h0;
    logic [1:0] rp = 2'h0;
    logic [15:0] o_next_pc;
    logic [7:0] o_wr_data, o_psw;
    logic ime_exp = 1'b0, tk;
    int err_count = 0, comparisons = 0, n_it;
    ////////////////////////////////////////////////////////////////////////////////
    // register operands come from the bench, psw and memory forms from the model
    assign operand = (i_op == btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R || i_space == btc_pkg::BTC_SP_ACC) ? reg_val
        : (i_space == btc_pkg::BTC_SP_PSW) ? psw_cur : mem_byte;
    assign mem_we = o_wr_en && (i_op == btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M || (i_op == btc_pkg::BTC_OP_BTCL
        && i_space != btc_pkg::BTC_SP_ACC && i_space != btc_pkg::BTC_SP_PSW));
    always #5 i_clk_sys = ~i_clk_sys;
    btc_core i_btc_core (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
        .i_space(i_space), .i_bit_sel(bit_sel), .i_operand(operand), .i_psw(psw_cur),
        .i_jump_displacement(disp), .i_pc(pc), .i_hsram(hsram), .i_wait_rd(wrd),
        .i_wait_wr(wwr), .i_register_pair(rp), .o_busy(o_busy), .o_done(o_done),
        .o_next_pc(o_next_pc), .o_branch_taken(o_branch_taken), .o_wr_en(o_wr_en),
        .o_wr_data(o_wr_data), .o_psw_wr(o_psw_wr), .o_psw(o_psw),
        .o_interrupt_master_enable(o_ime), .o_word_move_ok(o_wm_ok));
    btc_mem_model i_btc_mem_model (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(addr),
        .i_wr_en(mem_we), .i_wr_data(o_wr_data), .i_psw_wr(o_psw_wr), .i_psw(o_psw),
        .o_byte(mem_byte), .o_psw(psw_cur));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // cycle figure per form; fixed-count forms ignore the high-speed flag
    function automatic logic [7:0] exp_cyc(btc_pkg::btc_op_t op, btc_pkg::btc_space_t sp,
        logic hs, logic [3:0] n, logic [3:0] m);
        logic [7:0] s, l, f, p, h;
        case (op)
            btc_pkg::BTC_OP_BSET: {s, l, f, p, h} = {8'h08, 8'h09, 8'h0B, 8'h09, 8'h0B + 8'(n)};
            btc_pkg::BTC_OP_BCLR: {s, l, f, p, h} = {8'h0A, 8'h0B, 8'h0B, 8'h0B, 8'h0B + 8'(n)};
            btc_pkg::BTC_OP_BTCL: {s, l, f, p, h} = {8'h0A, 8'h0C, 8'h0C, 8'h0C,
                8'h0C + 8'(n) + 8'(m)};
            btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M: return hs ? 8'h08 : 8'h0A;
            default: return 8'h06;
        endcase
        case (sp)
            btc_pkg::BTC_SP_SADDR: return hs ? s : l;
            btc_pkg::BTC_SP_SFR: return f;
            btc_pkg::BTC_SP_ACC: return 8'h08;
            btc_pkg::BTC_SP_PSW: return p;
            default: return hs ? 8'h0A : h;
        endcase
    endfunction
    function automatic logic [2:0] exp_len(btc_pkg::btc_op_t op, btc_pkg::btc_space_t sp);
        if (op inside {btc_pkg::BTC_OP_NONE, btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_OP_IEN,
            btc_pkg::BTC_OP_IDIS}) return 3'h2;
        if (op == btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M) return 3'h3;
        if (sp inside {btc_pkg::BTC_SP_ACC, btc_pkg::BTC_SP_HL}) return 3'h3;
        if (sp == btc_pkg::BTC_SP_SFR || op != btc_pkg::BTC_OP_BSET) return 3'h4;
        return 3'h3;
    endfunction
    // one instruction: request, wait for done under a bound, compare the results (wr_en skipped for the psw test-and-clear)
    task automatic run(input btc_pkg::btc_op_t op, input btc_pkg::btc_space_t sp,
        input logic [2:0] bs, input logic [7:0] rv, input int a, input logic glitch);
        logic [7:0] opnd, wd;
        logic bitv, wr, pw;
        int cnt, extra;
        if (op == btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M) sp = btc_pkg::BTC_SP_SADDR;
        @(posedge i_clk_sys);
        i_op <= op;
        i_space <= sp;
        {bit_sel, reg_val, i_start} <= {bs, rv, 1'b1};
        {pc, disp, hsram, wrd, wwr} <= {16'($urandom), 8'($urandom), 1'($urandom), 8'($urandom)};
        addr <= (a < 0) ? 8'($urandom) : 8'(a);
        #1;
        opnd = operand;
        bitv = opnd[bs];
        wd = (op == btc_pkg::BTC_OP_BTCL) ? (opnd & ~(8'h01 << bs)) : opnd - 8'h01;
        case (op)
            btc_pkg::BTC_OP_BSET, btc_pkg::BTC_OP_BTCL: tk = bitv;
            btc_pkg::BTC_OP_BCLR: tk = !bitv;
            btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M: tk = (wd != 8'h00);
            default: tk = 1'b0;
        endcase
        wr = op inside {btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M}
            || (op == btc_pkg::BTC_OP_BTCL && bitv);
        pw = wr && op == btc_pkg::BTC_OP_BTCL && sp == btc_pkg::BTC_SP_PSW;
        if (op inside {btc_pkg::BTC_OP_IEN, btc_pkg::BTC_OP_IDIS}) ime_exp = (op == btc_pkg::BTC_OP_IEN);
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        cnt = 0;
        do begin
            @(posedge i_clk_sys);
            cnt++;
            i_start <= glitch && cnt == 2;
            #1;
            if (cnt == 1) chk("busy", 16'(o_busy), 16'h0001);
        end while (o_done !== 1'b1 && cnt < 60);
        // done stands in the cycle that closes at edge C, so it shows after edge C-1
        chk("cycles", 16'(cnt) + 16'h0001,
            16'(exp_cyc(op, sp, hsram, wrd, wwr)));
        chk("next_pc", o_next_pc, pc + 16'(exp_len(op, sp))
            + (tk ? {{8{disp[7]}}, disp} : 16'h0000));
        chk("taken", 16'(o_branch_taken), 16'(tk));
        if (!(op == btc_pkg::BTC_OP_BTCL && sp == btc_pkg::BTC_SP_PSW))
            chk("wr_en", 16'(o_wr_en), 16'(wr));
        if (wr) chk("wr_data", 16'(o_wr_data), 16'(wd));
        chk("psw_wr", 16'(o_psw_wr), 16'(pw));
        if (pw) chk("psw", 16'(o_psw), 16'(wd));
        chk("ime", 16'(o_ime), 16'(ime_exp));
        @(posedge i_clk_sys);
        #1;
        chk("done_pulse", 16'(o_done), 16'h0000);
        if (mem_we === 1'b0 && wr && i_space != btc_pkg::BTC_SP_PSW && i_space != btc_pkg::BTC_SP_ACC
            && op != btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R) chk("mem", 16'(mem_byte), 16'(wd));
        extra = 0;
        repeat (glitch ? 8 : 1) begin
            @(posedge i_clk_sys);
            #1;
            extra += int'(o_done === 1'b1);
        end
        chk("refused", 16'(extra), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the expected run of about six thousand cycles
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(87351));
        repeat (5) @(posedge i_clk_sys);
        #1;
        chk("rst_ime", 16'({o_ime, o_busy, o_done}), 16'h0000);
        i_rst_n <= 1'b1;
        // loop counter in memory: iterations equal the starting byte 0xD7
        n_it = 0;
        do begin
            run(btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_M, btc_pkg::BTC_SP_SADDR, 3'h0, 8'h00, 16, 1'b0);
            n_it++;
        end while (tk && n_it < 260);
        chk("loop_count", 16'(n_it), 16'h00D7);
        // register loop edges: two, one and wrap from zero
        for (int k = 0; k < 3; k++) begin
            run(btc_pkg::BTC_OP_DECREMENT_BRANCH_NONZERO_R, btc_pkg::BTC_SP_ACC, 3'h0, 8'h02 - 8'(k), -1, 1'b0);
        end
        run(btc_pkg::BTC_OP_BTCL, btc_pkg::BTC_SP_PSW, 3'h0, 8'h00, -1, 1'b0);
        run(btc_pkg::BTC_OP_IEN, btc_pkg::BTC_SP_SADDR, 3'h0, 8'h00, -1, 1'b1);
        run(btc_pkg::BTC_OP_IDIS, btc_pkg::BTC_SP_SADDR, 3'h0, 8'h00, -1, 1'b1);
        for (int r = 0; r < 4; r++) begin
            @(posedge i_clk_sys);
            rp <= 2'(r);
            @(posedge i_clk_sys);
            #1;
            chk("word_move", 16'(o_wm_ok), 16'(r != 0));
        end
        repeat (300) run(btc_pkg::btc_op_t'(3'($urandom_range(7, 0))),
            btc_pkg::btc_space_t'(3'($urandom_range(4, 0))), 3'($urandom), 8'($urandom), -1, 1'b0);
        print_verdict();
    end
endmodule
